// [bench/gsra_host.sv]
// Host model on the serial link: sends command bytes, collects reply bytes.
// Assumes 8N1 framing at BIT clocks per bit, both lines idle high.
`timescale 1ns/10ps
module gsra_host #(
    parameter int BIT = 1736
) (
    input wire logic i_clk,
    input wire logic i_tx,
    output logic o_rx
);
    // ----------------------------------------
    // Byte tasks, one line each way
    // ----------------------------------------
    initial o_rx = 1'b1;
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        @(posedge i_clk);
        for (int i = 0; i < 10; i++) begin
            #1;
            o_rx = f[i];
            repeat (BIT) @(posedge i_clk);
        end
    endtask : send_byte
    // Samples mid-bit; bounded wait so a silent device cannot hang us
    task automatic recv_byte(output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        while (i_tx === 1'b1 && n < 40000) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        repeat (BIT / 2) @(posedge i_clk);
        ok = (i_tx === 1'b0);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge i_clk);
            b[i] = i_tx;
        end
        repeat (BIT) @(posedge i_clk);
        ok = ok && (i_tx === 1'b1);
    endtask : recv_byte
endmodule : gsra_host

// [bench/gsra_readout_sva.sv]
// Checker for the readout core, watching its ports only.
// Assumes one clock domain; bound into every gsra_readout.
`timescale 1ns/10ps
module gsra_readout_sva import gsra_pkg::*; #(
    parameter int W = 16,
    parameter int P_SMP_CYC = 200
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_host_cmd_valid,
    input wire logic [7:0] i_host_cmd,
    input wire logic o_tx,
    input wire logic o_uart_sel,
    input wire logic o_meas_active,
    input wire logic o_smp_strobe,
    input wire logic o_rep_valid,
    input wire logic [7:0] o_rep_err,
    input wire logic [7:0] o_rep_len,
    input wire logic signed [W-1:0] o_rep_hcho
);
    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    logic i2c_cmd;
    int gap_r;
    logic first_r;
    int pwr_r;
    assign i2c_cmd = i_host_cmd_valid && !o_uart_sel;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            gap_r <= 0;
            first_r <= 1'b1;
            pwr_r <= 0;
        end else begin
            // Saturate so the count never wraps on long runs
            if (pwr_r < 20 * P_SMP_CYC) begin
                pwr_r <= pwr_r + 1;
            end
            if (i2c_cmd && i_host_cmd == CMD_START && !o_meas_active) begin
                gap_r <= 0;
                first_r <= 1'b1;
            end else if (o_smp_strobe) begin
                gap_r <= 0;
                first_r <= 1'b0;
            end else begin
                gap_r <= gap_r + 1;
            end
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    sequence s_start_idle;
        i2c_cmd && i_host_cmd == CMD_START && !o_meas_active;
    endsequence
    sequence s_start_busy;
        i2c_cmd && i_host_cmd == CMD_START && o_meas_active;
    endsequence
    sequence s_stop_idle;
        i2c_cmd && i_host_cmd == CMD_STOP && !o_meas_active;
    endsequence
    sequence s_stop_busy;
        i2c_cmd && i_host_cmd == CMD_STOP && o_meas_active;
    endsequence
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_start_enters: assert property (s_start_idle |=> o_meas_active && o_rep_valid && o_rep_err == ERR_NONE)
        else $error("start did not enter measurement");
    a_start_busy_err: assert property (s_start_busy |=> o_rep_valid && o_rep_err == ERR_STATE && o_meas_active)
        else $error("second start not refused");
    a_stop_leaves: assert property (s_stop_busy |=> !o_meas_active && o_rep_err == ERR_NONE)
        else $error("stop did not return to idle");
    a_stop_idle_err: assert property (s_stop_idle |=> o_rep_valid && o_rep_err == ERR_STATE)
        else $error("stop while idle not refused");
    a_strobe_gap: assert property (o_smp_strobe && !first_r |-> gap_r == P_SMP_CYC - 1)
        else $error("sample spacing wrong");
    a_idle_quiet: assert property (!o_meas_active |-> !o_smp_strobe && (!o_rep_valid || o_rep_len == LEN_EMPTY))
        else $error("sample or values while idle");
    a_no_data_empty: assert property (o_rep_valid && o_rep_err == ERR_NO_DATA |-> o_rep_len == LEN_EMPTY)
        else $error("no-data reply carries data");
    a_hcho_zero: assert property (o_rep_valid && pwr_r < 19 * P_SMP_CYC |-> o_rep_hcho == 0)
        else $error("formaldehyde not suppressed");
    a_tx_start: assert property (o_rep_valid && o_uart_sel |-> (!o_tx) [*8])
        else $error("reply start bit missing");
endmodule : gsra_readout_sva

bind gsra_readout gsra_readout_sva #(.W(W), .P_SMP_CYC(P_SMP_CYC)) i_gsra_readout_sva (
    .i_clk, .i_rst, .i_host_cmd_valid, .i_host_cmd, .o_tx, .o_uart_sel, .o_meas_active,
    .o_smp_strobe, .o_rep_valid, .o_rep_err, .o_rep_len, .o_rep_hcho
);

// [bench/gsra_readout_tb.sv]
// Testbench for the readout core: commands, averaging, suppression, serial link.
// Assumes design files, checker and host model are compiled first.
`timescale 1ns/10ps
module gsra_readout_tb;
    import gsra_pkg::*;
    localparam int P = 200;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_if_sel = 1'b0;
    logic i_rx;
    logic i_host_cmd_valid = 1'b0;
    logic [7:0] i_host_cmd = 8'h00;
    logic signed [15:0] i_hcho = 16'h0000;
    logic signed [15:0] i_humid = 16'h0000;
    logic signed [15:0] i_temp = 16'h0000;
    logic o_tx, o_uart_sel, o_meas_active, o_smp_strobe, o_rep_valid;
    logic [7:0] o_rep_err, o_rep_len;
    logic signed [15:0] o_rep_hcho, o_rep_humid, o_rep_temp;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    always #2.5 i_clk = ~i_clk;
    gsra_readout #(.W(16), .P_SMP_CYC(P)) i_gsra_readout (
        .i_clk, .i_rst, .i_if_sel, .i_rx, .i_host_cmd_valid, .i_host_cmd, .i_hcho, .i_humid, .i_temp,
        .o_tx, .o_uart_sel, .o_meas_active, .o_smp_strobe, .o_rep_valid, .o_rep_err, .o_rep_len,
        .o_rep_hcho, .o_rep_humid, .o_rep_temp
    );
    gsra_host i_host (.i_clk(i_clk), .i_tx(o_tx), .o_rx(i_rx));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    task automatic cmd(input logic [7:0] c);
        @(posedge i_clk);
        #1;
        i_host_cmd_valid = 1'b1;
        i_host_cmd = c;
        @(posedge i_clk);
        #1;
        i_host_cmd_valid = 1'b0;
    endtask : cmd
    task automatic rep(input logic [7:0] e, input logic [7:0] l);
        check(16'(o_rep_valid), 16'h0001);
        check({8'h00, o_rep_err}, {8'h00, e});
        check({8'h00, o_rep_len}, {8'h00, l});
    endtask : rep
    // Returns just after the edge that takes the n-th sample
    task automatic wait_strobe(input int n);
        int k;
        k = (n + 2) * P;
        while (n > 0 && k > 0) begin
            @(posedge i_clk);
            #1;
            if (o_smp_strobe === 1'b1) begin
                n--;
            end
            k--;
        end
        check(16'(n), 16'h0000);
        @(posedge i_clk);
        #1;
    endtask : wait_strobe
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_idle();
        check(16'(o_meas_active), 16'h0000);
        check(16'(o_uart_sel), 16'h0001);
        cmd(CMD_STOP);
        rep(ERR_STATE, LEN_EMPTY);
        check(16'(o_uart_sel), 16'h0000);
        cmd(8'h55);
        check(16'(o_rep_valid), 16'h0000);
        check({8'h00, o_rep_err}, {8'h00, ERR_STATE});
        cmd(CMD_READ);
        rep(ERR_NONE, LEN_EMPTY);
    endtask : t_idle
    task automatic t_mean();
        i_hcho = 16'h0064;
        i_humid = 16'h000a;
        i_temp = 16'hfffd;
        cmd(CMD_START);
        rep(ERR_NONE, LEN_EMPTY);
        cmd(CMD_START);
        rep(ERR_STATE, LEN_EMPTY);
        cmd(CMD_READ);
        rep(ERR_NO_DATA, LEN_EMPTY);
        wait_strobe(1);
        i_humid = 16'h000f;
        i_temp = 16'hfffc;
        wait_strobe(1);
        cmd(CMD_READ);
        rep(ERR_NONE, LEN_VALUES);
        check(o_rep_hcho, 16'h0000);
        check(o_rep_humid, 16'h000c);
        check(o_rep_temp, 16'hfffd);
        cmd(CMD_READ);
        rep(ERR_NONE, LEN_VALUES);
        check(o_rep_humid, 16'h000c);
        wait_strobe(1);
        cmd(CMD_READ);
        check(o_rep_humid, 16'h000f);
        cmd(CMD_STOP);
        rep(ERR_NONE, LEN_EMPTY);
        check(16'(o_meas_active), 16'h0000);
    endtask : t_mean
    // A step after a full mean window tells smoothing from a longer mean
    task automatic t_smooth();
        int e;
        e = 1000 + 1000 * int'(ALPHA_Q16) / 65536;
        i_hcho = 16'h03e8;
        i_humid = 16'h03e8;
        cmd(CMD_START);
        wait_strobe(120);
        i_hcho = 16'h07d0;
        i_humid = 16'h07d0;
        wait_strobe(1);
        cmd(CMD_READ);
        check(o_rep_humid, 16'(e));
        check(o_rep_hcho, 16'(e));
        cmd(CMD_STOP);
    endtask : t_smooth
    task automatic t_uart();
        logic [7:0] b;
        logic ok;
        i_if_sel = 1'b1;
        repeat (2) @(posedge i_clk);
        #1;
        check(16'(o_uart_sel), 16'h0001);
        fork
            i_host.send_byte(CMD_STOP);
            begin
                i_host.recv_byte(b, ok);
                check({8'h00, b}, {8'h00, ERR_STATE});
                check(16'(ok), 16'h0001);
                i_host.recv_byte(b, ok);
                check({8'h00, b}, {8'h00, LEN_EMPTY});
                check(16'(ok), 16'h0001);
            end
        join
    endtask : t_uart
    // ----------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 95000) begin
            err_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        t_idle();
        t_mean();
        t_smooth();
        t_uart();
        print_verdict();
    end
endmodule : gsra_readout_tb

// [hw/gsra_chan.sv]
// One signal's averager: running mean, then exponential smoothing.
// Assumes samples are signed two's complement and arrive as one-cycle pulses.
`timescale 1ns/10ps
module gsra_chan import gsra_pkg::*; #(
    parameter int W = 16,
    parameter int CNT_W = 8,
    parameter int N = MEAN_SAMPLES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_clr,
    input wire logic i_smp,
    input wire logic signed [W-1:0] i_x,
    output logic signed [W-1:0] o_val
);
    localparam int ACC_W = W + CNT_W;
    localparam int S_W = W + FRAC_W;

    typedef struct packed {
        logic signed [ACC_W-1:0] acc;
        logic [CNT_W-1:0] cnt;
        logic signed [S_W-1:0] s;
        logic signed [W-1:0] res;
    } gsra_chan_s;

    gsra_chan_s q_r;
    gsra_chan_s q_nxt;

    always_comb begin
        logic signed [ACC_W-1:0] acc_b;
        logic [CNT_W-1:0] cnt_b;
        logic signed [ACC_W-1:0] quo;
        logic signed [S_W:0] diff;
        logic signed [S_W+17:0] prod;
        acc_b = '0;
        cnt_b = '0;
        quo = '0;
        diff = '0;
        prod = '0;
        q_nxt = q_r;
        // A sample landing with a clear opens the new window
        acc_b = i_clr ? '0 : q_r.acc;
        cnt_b = i_clr ? '0 : q_r.cnt;
        if (i_smp) begin
            if (cnt_b < CNT_W'(N)) begin
                q_nxt.acc = acc_b + {{CNT_W{i_x[W-1]}}, i_x};
                q_nxt.cnt = cnt_b + 1'b1;
                quo = q_nxt.acc / $signed({1'b0, q_nxt.cnt});
                q_nxt.res = quo[W-1:0];
                if (q_nxt.cnt == CNT_W'(N)) begin
                    q_nxt.s = {quo[W-1:0], {FRAC_W{1'b0}}};
                end
            end else begin
                // Q16 alpha; 1094/65536 stays within 0.05% of 0.0167
                diff = {i_x[W-1], i_x, {FRAC_W{1'b0}}} - {q_r.s[S_W-1], q_r.s};
                prod = diff * $signed({1'b0, ALPHA_Q16});
                q_nxt.s = q_r.s + prod[S_W+FRAC_W-1:FRAC_W];
                q_nxt.res = q_nxt.s[S_W-1:FRAC_W];
            end
        end else begin
            q_nxt.acc = acc_b;
            q_nxt.cnt = cnt_b;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign o_val = q_r.res;
endmodule : gsra_chan

// [hw/gsra_pkg.sv]
// Constants shared by the averaging readout core of the gas/humidity/temperature module.
// Assumes a single 200 MHz clock and an external frame layer or I2C engine for host framing.
//
// Behaviour
// - Interface select high or floating picks UART, low picks the I2C command port.
// - Start command enters continuous measurement; it stays there until stop.
// - While measuring, one sample of all three signals every half second.
// - Reported value averages all samples since previous read; a read restarts the window.
// - First sixty seconds: plain mean, accumulated sum divided by sample count.
// - Beyond sixty seconds: exponential smoothing, new sample weighted 0.0167.
// - Smoothing seeded with the sixty-second mean; read returns newest smoothed value.
// - No data returned during first half second after start.
// - Read without a new sample since last read resends previous values unchanged.
// - Formaldehyde output forced to zero until ten seconds after power-up.
// - Humidity and temperature are never suppressed after power-up.
// - Serial link runs 115200 baud, eight data bits, no parity, one stop.
// - Separate receive line in and transmit line out, never shared.
// - After reset the block idles and produces no values until start.
// - Read before first sample after start answers empty with error 0x20.
// - Stop returns to idle; stop while idle answers error 0x43.
package gsra_pkg;

    // ------------------------------------------------------------
    // Clock and times
    // ------------------------------------------------------------
    localparam int CLK_HZ = 200000000;
    localparam int SMP_PERIOD_MS = 500;
    localparam int SMP_CYC = (CLK_HZ / 1000) * SMP_PERIOD_MS;
    localparam int MEAN_WINDOW_S = 60;
    localparam int PWR_SUPP_S = 10;
    localparam int MEAN_SAMPLES = (MEAN_WINDOW_S * 1000) / SMP_PERIOD_MS;
    localparam int PWR_TICKS = (PWR_SUPP_S * 1000) / SMP_PERIOD_MS;
    localparam int UART_BAUD = 115200;
    localparam int BAUD_CYC = CLK_HZ / UART_BAUD;

    // ------------------------------------------------------------
    // Widths and fixed-point
    // ------------------------------------------------------------
    localparam int BAUD_W = 11;
    localparam int PWR_W = 5;
    localparam int FRAC_W = 16;
    localparam int ALPHA_E4 = 167;
    localparam logic [15:0] ALPHA_Q16 = 16'((ALPHA_E4 * 65536 + 5000) / 10000);
    localparam logic [BAUD_W-1:0] BAUD_LAST = BAUD_W'(BAUD_CYC - 1);
    localparam logic [BAUD_W-1:0] BAUD_HALF = BAUD_W'(BAUD_CYC / 2);
    localparam logic [PWR_W-1:0] PWR_LIMIT = PWR_W'(PWR_TICKS);
    localparam logic [3:0] UART_STOP_BIT = 4'h9;

    // ------------------------------------------------------------
    // Commands, answers
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_START = 8'h00;
    localparam logic [7:0] CMD_STOP = 8'h01;
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_NO_DATA = 8'h20;
    localparam logic [7:0] ERR_STATE = 8'h43;
    localparam logic [7:0] LEN_EMPTY = 8'h00;
    localparam logic [7:0] LEN_VALUES = 8'h06;

    typedef enum logic [1:0] {
        GSRA_IDLE = 2'h1,
        GSRA_MEAS = 2'h2
    } gsra_state_e;

endpackage : gsra_pkg

// [hw/gsra_readout.sv]
// Readout core: measurement mode control, averaging, power-up gating and 8N1 serial link.
// Assumes a front end presenting current sample values and, in I2C mode, an external
// engine that delivers decoded command bytes and collects the reply from the o_rep ports.
`timescale 1ns/10ps
module gsra_readout import gsra_pkg::*; #(
    parameter int W = 16,
    parameter int P_SMP_CYC = SMP_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_if_sel,
    input wire logic i_rx,
    input wire logic i_host_cmd_valid,
    input wire logic [7:0] i_host_cmd,
    input wire logic signed [W-1:0] i_hcho,
    input wire logic signed [W-1:0] i_humid,
    input wire logic signed [W-1:0] i_temp,
    output logic o_tx,
    output logic o_uart_sel,
    output logic o_meas_active,
    output logic o_smp_strobe,
    output logic o_rep_valid,
    output logic [7:0] o_rep_err,
    output logic [7:0] o_rep_len,
    output logic signed [W-1:0] o_rep_hcho,
    output logic signed [W-1:0] o_rep_humid,
    output logic signed [W-1:0] o_rep_temp
);
    typedef struct packed {
        gsra_state_e st;
        logic have;
        logic fresh;
        logic [PWR_W-1:0] pwr;
        logic uart;
        logic rx_busy;
        logic [3:0] rx_bit;
        logic [BAUD_W-1:0] rx_cnt;
        logic [7:0] rx_sh;
        logic tx_busy;
        logic [2:0] tx_idx;
        logic [3:0] tx_bit;
        logic [BAUD_W-1:0] tx_cnt;
        logic [9:0] tx_sh;
        logic tx_line;
        logic rep_valid;
        logic [7:0] rep_err;
        logic [7:0] rep_len;
        logic signed [W-1:0] rep_hcho;
        logic signed [W-1:0] rep_humid;
        logic signed [W-1:0] rep_temp;
    } gsra_top_s;

    gsra_top_s q_r;
    gsra_top_s q_nxt;

    logic smp_tick;
    logic pwr_tick;
    logic chan_clr;
    logic smp_take;
    logic smp_restart;
    logic signed [W-1:0] smp_in [3];
    logic signed [W-1:0] avg [3];

    // ------------------------------------------------------------
    // Timebases
    // ------------------------------------------------------------
    // Sample timer restarts on start so the first sample lands a half second later
    gsra_tick #(.DIV(P_SMP_CYC), .CW(27)) u_smp_tick (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_clr(smp_restart),
        .o_tick(smp_tick)
    );

    gsra_tick #(.DIV(P_SMP_CYC), .CW(27)) u_pwr_tick (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_clr(1'b0),
        .o_tick(pwr_tick)
    );

    // ------------------------------------------------------------
    // Per-signal averagers
    // ------------------------------------------------------------
    assign smp_take = smp_tick && (q_r.st == GSRA_MEAS);
    // Reads restart the window only; the timer keeps the half-second cadence
    assign smp_restart = chan_clr && (q_r.st == GSRA_IDLE);
    assign smp_in[0] = i_hcho;
    assign smp_in[1] = i_humid;
    assign smp_in[2] = i_temp;

    for (genvar g = 0; g < 3; g++) begin : g_chan
        gsra_chan #(.W(W), .CNT_W(8), .N(MEAN_SAMPLES)) u_chan (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_clr(chan_clr),
            .i_smp(smp_take),
            .i_x(smp_in[g]),
            .o_val(avg[g])
        );
    end

    // ------------------------------------------------------------
    // Reply byte selection for the serial sender
    // ------------------------------------------------------------
    function automatic logic [7:0] rep_byte(input gsra_top_s s, input logic [2:0] idx);
        logic [7:0] b;
        b = 8'h00;
        case (idx)
            3'h0: b = s.rep_err;
            3'h1: b = s.rep_len;
            3'h2: b = s.rep_hcho[W-1:W-8];
            3'h3: b = s.rep_hcho[7:0];
            3'h4: b = s.rep_humid[W-1:W-8];
            3'h5: b = s.rep_humid[7:0];
            3'h6: b = s.rep_temp[W-1:W-8];
            default: b = s.rep_temp[7:0];
        endcase
        return b;
    endfunction : rep_byte

    // ------------------------------------------------------------
    // Control
    // ------------------------------------------------------------
    always_comb begin
        logic cmd_v;
        logic [7:0] cmd;
        logic rx_done;
        logic clr;
        cmd_v = 1'b0;
        cmd = 8'h00;
        rx_done = 1'b0;
        clr = 1'b0;
        q_nxt = q_r;
        q_nxt.rep_valid = 1'b0;
        q_nxt.uart = i_if_sel;

        // Power-up suppression counter, counting from reset and holding at PWR_LIMIT
        if (pwr_tick && q_r.pwr != PWR_LIMIT) begin
            q_nxt.pwr = q_r.pwr + 1'b1;
        end

        // Receiver: start bit checked mid-bit, then one sample per bit time
        if (!q_r.uart) begin
            q_nxt.rx_busy = 1'b0;
        end else if (!q_r.rx_busy) begin
            if (!i_rx) begin
                q_nxt.rx_busy = 1'b1;
                q_nxt.rx_cnt = BAUD_HALF;
                q_nxt.rx_bit = 4'h0;
            end
        end else if (q_r.rx_cnt != '0) begin
            q_nxt.rx_cnt = q_r.rx_cnt - 1'b1;
        end else begin
            q_nxt.rx_cnt = BAUD_LAST;
            if (q_r.rx_bit == 4'h0) begin
                q_nxt.rx_busy = ~i_rx;
                q_nxt.rx_bit = 4'h1;
            end else if (q_r.rx_bit == UART_STOP_BIT) begin
                q_nxt.rx_busy = 1'b0;
                rx_done = i_rx;
            end else begin
                q_nxt.rx_sh = {i_rx, q_r.rx_sh[7:1]};
                q_nxt.rx_bit = q_r.rx_bit + 1'b1;
            end
        end

        // Serial commands are dropped while a reply is still going out
        if (q_r.uart) begin
            cmd_v = rx_done && !q_r.tx_busy;
            cmd = q_r.rx_sh;
        end else begin
            cmd_v = i_host_cmd_valid;
            cmd = i_host_cmd;
        end

        // New sample wins over the clear of a read in the same cycle
        if (smp_take) begin
            q_nxt.have = 1'b1;
            q_nxt.fresh = 1'b1;
        end

        if (cmd_v) begin
            q_nxt.rep_valid = 1'b1;
            q_nxt.rep_err = ERR_NONE;
            q_nxt.rep_len = LEN_EMPTY;
            case (cmd)
                CMD_START: begin
                    if (q_r.st == GSRA_IDLE) begin
                        q_nxt.st = GSRA_MEAS;
                        q_nxt.have = 1'b0;
                        q_nxt.fresh = 1'b0;
                        clr = 1'b1;
                    end else begin
                        q_nxt.rep_err = ERR_STATE;
                    end
                end
                CMD_STOP: begin
                    if (q_r.st == GSRA_MEAS) begin
                        q_nxt.st = GSRA_IDLE;
                    end else begin
                        q_nxt.rep_err = ERR_STATE;
                    end
                end
                CMD_READ: begin
                    if (q_r.st != GSRA_MEAS) begin
                        q_nxt.rep_err = ERR_NONE;
                    end else if (!q_r.have) begin
                        q_nxt.rep_err = ERR_NO_DATA;
                    end else begin
                        q_nxt.rep_len = LEN_VALUES;
                        if (q_r.fresh) begin
                            q_nxt.rep_hcho = (q_r.pwr == PWR_LIMIT) ? avg[0] : '0;
                            q_nxt.rep_humid = avg[1];
                            q_nxt.rep_temp = avg[2];
                            q_nxt.fresh = smp_take;
                            clr = 1'b1;
                        end
                        // Otherwise earlier values stand and are sent again
                    end
                end
                default: begin
                    // Unknown codes leave the last reply standing
                    q_nxt.rep_valid = 1'b0;
                    q_nxt.rep_err = q_r.rep_err;
                    q_nxt.rep_len = q_r.rep_len;
                end
            endcase
        end

        // Sender: error, length, then the rep_len value bytes (none for empty replies), high byte first
        if (q_r.uart && q_nxt.rep_valid) begin
            q_nxt.tx_busy = 1'b1;
            q_nxt.tx_idx = 3'h0;
            q_nxt.tx_bit = 4'h0;
            q_nxt.tx_cnt = BAUD_LAST;
            q_nxt.tx_sh = {1'b1, rep_byte(q_nxt, 3'h0), 1'b0};
            q_nxt.tx_line = 1'b0;
        end else if (q_r.tx_busy) begin
            if (q_r.tx_cnt != '0) begin
                q_nxt.tx_cnt = q_r.tx_cnt - 1'b1;
            end else begin
                q_nxt.tx_cnt = BAUD_LAST;
                if (q_r.tx_bit != UART_STOP_BIT) begin
                    q_nxt.tx_bit = q_r.tx_bit + 1'b1;
                    q_nxt.tx_sh = {1'b1, q_r.tx_sh[9:1]};
                    q_nxt.tx_line = q_r.tx_sh[1];
                end else if ({5'h00, q_r.tx_idx} == q_r.rep_len + 8'h01) begin
                    q_nxt.tx_busy = 1'b0;
                    q_nxt.tx_line = 1'b1;
                end else begin
                    q_nxt.tx_idx = q_r.tx_idx + 1'b1;
                    q_nxt.tx_bit = 4'h0;
                    q_nxt.tx_sh = {1'b1, rep_byte(q_r, q_r.tx_idx + 1'b1), 1'b0};
                    q_nxt.tx_line = 1'b0;
                end
            end
        end
        chan_clr = clr;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q_r <= '0;
            q_r.st <= GSRA_IDLE;
            q_r.uart <= 1'b1;
            q_r.tx_line <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_tx = q_r.tx_line;
    assign o_uart_sel = q_r.uart;
    assign o_meas_active = (q_r.st == GSRA_MEAS);
    assign o_smp_strobe = smp_take;
    assign o_rep_valid = q_r.rep_valid;
    assign o_rep_err = q_r.rep_err;
    assign o_rep_len = q_r.rep_len;
    assign o_rep_hcho = q_r.rep_hcho;
    assign o_rep_humid = q_r.rep_humid;
    assign o_rep_temp = q_r.rep_temp;
endmodule : gsra_readout

// [hw/gsra_tick.sv]
// Restartable prescaler giving a one-cycle enable every DIV clocks.
// Assumes DIV of at least two.
`timescale 1ns/10ps
module gsra_tick import gsra_pkg::*; #(
    parameter int DIV = SMP_CYC,
    parameter int CW = 27
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_clr,
    output logic o_tick
);
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } gsra_tick_s;

    gsra_tick_s q_r;
    gsra_tick_s q_nxt;

    always_comb begin
        q_nxt = q_r;
        q_nxt.tick = 1'b0;
        if (i_clr) begin
            q_nxt.cnt = '0;
        end else if (q_r.cnt == CW'(DIV - 1)) begin
            q_nxt.cnt = '0;
            q_nxt.tick = 1'b1;
        end else begin
            q_nxt.cnt = q_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign o_tick = q_r.tick;
endmodule : gsra_tick
